// >>> hw/idm_pkg.sv
// Package with the address map, reset values and access types of the internal data space
package idm_pkg;

  // ******************************************************************
  // Address map
  // ******************************************************************
  localparam logic [7:0] IDM_BIT_RAM_BASE = 8'h20;
  localparam logic [7:0] IDM_STACK_ADDR = 8'h81;
  localparam logic [7:0] IDM_DATA_PTR_LO_ADDR = 8'h82;
  localparam logic [7:0] IDM_DATA_PTR_HI_ADDR = 8'h83;
  localparam logic [7:0] IDM_STATUS_ADDR = 8'hd0;
  localparam logic [7:0] IDM_ACCUM_ADDR = 8'he0;
  localparam logic [7:0] IDM_MULT_ADDR = 8'hf0;

  // ******************************************************************
  // Field positions and reset values
  // ******************************************************************
  localparam int IDM_STATUS_BANK_LO = 3;
  localparam int IDM_STATUS_BANK_HI = 4;
  localparam logic [7:0] IDM_STACK_RESET = 8'h07;
  localparam logic [7:0] IDM_REG_RESET = 8'h00;
  localparam logic [7:0] IDM_SFR_EMPTY = 8'h00;

  // ******************************************************************
  // Access kinds and request carrier
  // ******************************************************************
  typedef enum logic [2:0] {
    IDM_DIRECT,
    IDM_INDIRECT,
    IDM_REGISTER,
    IDM_BIT,
    IDM_PUSH
  } idm_kind_type;

  typedef struct packed {
    idm_kind_type kind;
    logic write;
    logic [7:0] addr;
    logic [7:0] wdata;
  } idm_req_type;

endpackage

// >>> hw/idm_ram.sv
// Single-port data RAM with registered read data
`timescale 1ns/100ps
module idm_ram #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 256,
  parameter int AW = 8
) (
  // Clock
  input wire logic clk,
  // Access port
  input wire logic we,
  input wire logic [AW-1:0] addr,
  input wire logic [WIDTH-1:0] wdata,
  output logic [WIDTH-1:0] rdata
);

  logic [WIDTH-1:0] mem [DEPTH];

  // No reset on the array; contents are undefined until written
  always_ff @(posedge clk) begin
    if (we) begin
      mem[addr] <= wdata;
    end
    rdata <= mem[addr];
  end

endmodule

// >>> hw/idm_data_space.sv
// Internal data space decoder: banks, bit area, stack and core registers
// ******************************************************************
// ******************************************************************
`timescale 1ns/100ps
module idm_data_space
  import idm_pkg::*;
#(
  parameter int RAM_DEPTH = 256
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Request from the core
  input wire logic req_valid,
  input wire idm_req_type req,
  output logic req_ready,
  // Answer to the core
  output logic resp_valid,
  output logic [7:0] resp_data,
  // Core register contents
  output logic [7:0] stack_pointer,
  output logic [7:0] data_pointer_low,
  output logic [7:0] data_pointer_high,
  output logic [7:0] program_status_word,
  output logic [7:0] accumulator,
  output logic [7:0] multiply_operand
);

  // ******************************************************************
  // Declarations
  // ******************************************************************
  typedef enum logic [1:0] {ST_IDLE, ST_PTR, ST_READ} idm_state_type;

  idm_state_type state_reg, state_next;
  idm_req_type req_reg;
  logic [7:0] tgt_reg;
  logic ready_reg, resp_valid_reg;
  logic [7:0] resp_data_reg, resp_data_next;
  logic [7:0] stack_reg, data_lo_reg, data_hi_reg, status_reg, accum_reg, mult_reg;
  logic [1:0] bank;
  logic accept;
  logic [7:0] tgt_addr;
  logic to_sfr;
  logic ram_we;
  logic [7:0] ram_addr, ram_wdata, ram_rdata;
  logic sfr_we;
  logic [7:0] sfr_waddr, sfr_wval, sfr_byte;

  // ******************************************************************
  // Helpers
  // ******************************************************************
  // Working register n of bank b sits at byte b*8+n
  function automatic logic [7:0] bank_addr(input logic [1:0] b, input logic [2:0] n);
    return {3'h0, b, n};
  endfunction

  // Byte holding a bit: low half is the bit area, high half the 0/8 registers
  function automatic logic [7:0] bit_byte(input logic [7:0] baddr);
    if (baddr[7]) begin
      return {baddr[7:3], 3'h0};
    end
    return 8'(IDM_BIT_RAM_BASE + {4'h0, baddr[6:3]});
  endfunction

  // Byte with one bit replaced
  function automatic logic [7:0] set_bit(input logic [7:0] b, input logic [2:0] pos,
                                         input logic v);
    logic [7:0] r;
    r = b;
    r[pos] = v;
    return r;
  endfunction

  // Core register read; unoccupied addresses read as zero
  function automatic logic [7:0] sfr_read(input logic [7:0] a, input logic [7:0] st,
                                          input logic [7:0] dl, input logic [7:0] dh,
                                          input logic [7:0] ps, input logic [7:0] ac,
                                          input logic [7:0] mu);
    unique case (a)
      IDM_STACK_ADDR: return st;
      IDM_DATA_PTR_LO_ADDR: return dl;
      IDM_DATA_PTR_HI_ADDR: return dh;
      IDM_STATUS_ADDR: return ps;
      IDM_ACCUM_ADDR: return ac;
      IDM_MULT_ADDR: return mu;
      default: return IDM_SFR_EMPTY;
    endcase
  endfunction

  // ******************************************************************
  // Decode of a new request
  // ******************************************************************
  assign bank = status_reg[IDM_STATUS_BANK_HI:IDM_STATUS_BANK_LO];
  assign accept = req_valid && ready_reg;

  // Target byte and space for every kind; indirect targets its pointer register in the active bank
  always_comb begin
    tgt_addr = req.addr;
    to_sfr = 1'b0;
    unique case (req.kind)
      IDM_DIRECT: begin
        tgt_addr = req.addr;
        to_sfr = req.addr[7];
      end
      IDM_REGISTER: tgt_addr = bank_addr(bank, req.addr[2:0]);
      IDM_BIT: begin
        tgt_addr = bit_byte(req.addr);
        to_sfr = req.addr[7];
      end
      IDM_PUSH: tgt_addr = 8'(stack_reg + 8'h01);
      IDM_INDIRECT: tgt_addr = bank_addr(bank, {2'h0, req.addr[0]});
      default: tgt_addr = req.addr;
    endcase
  end

  // Core register writes, bit writes done as read-modify-write in one cycle
  always_comb begin
    sfr_byte = sfr_read(tgt_addr, stack_reg, data_lo_reg, data_hi_reg, status_reg, accum_reg,
                        mult_reg);
    sfr_we = accept && to_sfr && req.write;
    sfr_waddr = tgt_addr;
    sfr_wval = (req.kind == IDM_BIT) ? set_bit(sfr_byte, req.addr[2:0], req.wdata[0])
                                     : req.wdata;
  end

  // ******************************************************************
  // RAM port steering and sequencing
  // ******************************************************************
  always_comb begin
    state_next = state_reg;
    ram_we = 1'b0;
    ram_addr = tgt_addr;
    ram_wdata = req.wdata;
    resp_data_next = 8'h00;
    unique case (state_reg)
      ST_IDLE: begin
        if (accept) begin
          if (req.kind == IDM_INDIRECT) begin
            state_next = ST_PTR;
          end else if (to_sfr) begin
            if (!req.write) begin
              resp_data_next = (req.kind == IDM_BIT) ? {7'h00, sfr_byte[req.addr[2:0]]}
                                                     : sfr_byte;
            end
          end else if ((req.write || req.kind == IDM_PUSH) && req.kind != IDM_BIT) begin
            ram_we = 1'b1;
          end else begin
            state_next = ST_READ;
          end
        end
      end
      ST_PTR: begin
        // Pointer may exceed 0x7f: indirect reaches the upper RAM half
        ram_addr = ram_rdata;
        ram_wdata = req_reg.wdata;
        if (req_reg.write) begin
          ram_we = 1'b1;
          state_next = ST_IDLE;
        end else begin
          state_next = ST_READ;
        end
      end
      ST_READ: begin
        ram_addr = tgt_reg;
        state_next = ST_IDLE;
        if (req_reg.kind == IDM_BIT) begin
          if (req_reg.write) begin
            ram_we = 1'b1;
            ram_wdata = set_bit(ram_rdata, req_reg.addr[2:0], req_reg.wdata[0]);
          end else begin
            resp_data_next = {7'h00, ram_rdata[req_reg.addr[2:0]]};
          end
        end else begin
          resp_data_next = ram_rdata;
        end
      end
    endcase
  end

  idm_ram #(.WIDTH(8), .DEPTH(RAM_DEPTH), .AW(8)) u_ram (
    .clk(clk),
    .we(ram_we),
    .addr(ram_addr),
    .wdata(ram_wdata),
    .rdata(ram_rdata)
  );

  // Sequencer state and handshake
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_reg <= ST_IDLE;
      ready_reg <= 1'b1;
      resp_valid_reg <= 1'b0;
      resp_data_reg <= 8'h00;
    end else begin
      state_reg <= state_next;
      ready_reg <= (state_next == ST_IDLE);
      resp_valid_reg <= (state_reg != ST_IDLE || accept) && state_next == ST_IDLE;
      resp_data_reg <= resp_data_next;
    end
  end

  // Request capture; target remembered for the second RAM cycle
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      req_reg <= '0;
      tgt_reg <= 8'h00;
    end else if (accept) begin
      req_reg <= req;
      tgt_reg <= tgt_addr;
    end else if (state_reg == ST_PTR) begin
      tgt_reg <= ram_rdata;
    end
  end

  // ******************************************************************
  // Core registers
  // ******************************************************************
  // Stack pointer: 8 bits, so increment wraps past 0xff by itself
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      stack_reg <= IDM_STACK_RESET;
    end else if (accept && req.kind == IDM_PUSH) begin
      stack_reg <= 8'(stack_reg + 8'h01);
    end else if (sfr_we && sfr_waddr == IDM_STACK_ADDR) begin
      stack_reg <= sfr_wval;
    end
  end

  // Other core registers, written only through direct or bit access
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      data_lo_reg <= IDM_REG_RESET;
      data_hi_reg <= IDM_REG_RESET;
      status_reg <= IDM_REG_RESET;
      accum_reg <= IDM_REG_RESET;
      mult_reg <= IDM_REG_RESET;
    end else if (sfr_we) begin
      if (sfr_waddr == IDM_DATA_PTR_LO_ADDR) data_lo_reg <= sfr_wval;
      if (sfr_waddr == IDM_DATA_PTR_HI_ADDR) data_hi_reg <= sfr_wval;
      if (sfr_waddr == IDM_STATUS_ADDR) status_reg <= sfr_wval;
      if (sfr_waddr == IDM_ACCUM_ADDR) accum_reg <= sfr_wval;
      if (sfr_waddr == IDM_MULT_ADDR) mult_reg <= sfr_wval;
    end
  end

  assign req_ready = ready_reg;
  assign resp_valid = resp_valid_reg;
  assign resp_data = resp_data_reg;
  assign stack_pointer = stack_reg;
  assign data_pointer_low = data_lo_reg;
  assign data_pointer_high = data_hi_reg;
  assign program_status_word = status_reg;
  assign accumulator = accum_reg;
  assign multiply_operand = mult_reg;

  // ******************************************************************
  // Checks
  // ******************************************************************
  chk_push_addr: assert property (@(posedge clk) disable iff (!rst_b)
    accept && req.kind == IDM_PUSH |-> ram_we && ram_addr == 8'(stack_reg + 8'h01))
    else $error("push not written above stack pointer");

  chk_push_incr: assert property (@(posedge clk) disable iff (!rst_b)
    accept && req.kind == IDM_PUSH |=> stack_reg == 8'($past(stack_reg) + 8'h01))
    else $error("stack pointer not incremented on push");

  chk_stack_reset: assert property (@(posedge clk)
    $rose(rst_b) |-> stack_reg == IDM_STACK_RESET)
    else $error("stack pointer reset value wrong");

  chk_bank_select: assert property (@(posedge clk) disable iff (!rst_b)
    accept && req.kind == IDM_REGISTER |->
      ram_addr == {3'h0, status_reg[4:3], req.addr[2:0]})
    else $error("working register outside active bank");

  chk_indirect_ptr: assert property (@(posedge clk) disable iff (!rst_b)
    accept && req.kind == IDM_INDIRECT |->
      ram_addr == {3'h0, status_reg[4:3], 2'h0, req.addr[0]} ##1 state_reg == ST_PTR)
    else $error("indirect pointer not fetched from bank register");

  chk_bit_map: assert property (@(posedge clk) disable iff (!rst_b)
    accept && req.kind == IDM_BIT && !req.addr[7] |->
      ram_addr == 8'h20 + {4'h0, req.addr[6:3]})
    else $error("bit address mapped to wrong byte");

  chk_sfr_route: assert property (@(posedge clk) disable iff (!rst_b)
    accept && req.kind == IDM_DIRECT && req.addr[7] |-> !ram_we ##1 resp_valid_reg)
    else $error("direct high address reached RAM");

  chk_stack_write: assert property (@(posedge clk) disable iff (!rst_b)
    accept && to_sfr && req.write && req.kind == IDM_DIRECT && req.addr == 8'h81
      |=> stack_reg == $past(req.wdata))
    else $error("stack pointer not written at 0x81");

  chk_upper_ind: assert property (@(posedge clk) disable iff (!rst_b)
    state_reg == ST_PTR |-> ram_addr == ram_rdata && !sfr_we)
    else $error("indirect access not sent to RAM");

  chk_read_timing: assert property (@(posedge clk) disable iff (!rst_b)
    accept && !req.write && req.kind == IDM_REGISTER |=> !resp_valid_reg ##1 resp_valid_reg)
    else $error("RAM read answer not two cycles later");

endmodule

// >>> testbench/idm_core_model.sv
// Core-side request model that drives the internal data space
`timescale 1ns/100ps
module idm_core_model
  import idm_pkg::*;
(
  // Clock
  input wire logic clk,
  // Answer from the data space
  input wire logic req_ready,
  input wire logic resp_valid,
  input wire logic [7:0] resp_data,
  // Request to the data space
  output logic req_valid,
  output idm_req_type req
);
  initial begin
    req_valid = 1'b0;
    req = '0;
  end

  // One access: held until taken, then a bounded wait for the answer
  task automatic access(input idm_kind_type kind, input logic wr, input logic [7:0] addr,
                        input logic [7:0] wdata, input int gap, output logic [7:0] data,
                        output int lat);
    int i;
    repeat (gap) @(posedge clk);
    req_valid <= 1'b1;
    req <= '{kind: kind, write: wr, addr: addr, wdata: wdata};
    do @(posedge clk); while (req_ready !== 1'b1);
    req_valid <= 1'b0;
    // Released address and data fields show garbage so a late sample cannot pass by luck
    req.addr <= ~addr;
    req.wdata <= ~wdata;
    data = 8'hxx;
    lat = -1;
    for (i = 0; i < 8; i++) begin
      @(posedge clk);
      if (resp_valid === 1'b1) begin
        data = resp_data;
        // Latency counts edges after the take, so a one-cycle answer reads 1
        lat = i + 1;
        break;
      end
    end
  endtask
endmodule

// >>> testbench/tb.sv
// Self-checking bench for the internal data space decoder
`timescale 1ns/100ps
`define CHK(got, exp) begin \
  n_compared++; \
  if ((got) !== (exp)) begin \
    fails++; \
    $display("unexpected at %0t: got %h expected %h", $time, (got), (exp)); \
  end \
end
module tb import idm_pkg::*; ;
  logic clk, rst_b, req_valid, req_ready, resp_valid;
  idm_req_type req;
  logic [7:0] resp_data, stack_pointer, data_pointer_low, data_pointer_high;
  logic [7:0] program_status_word, accumulator, multiply_operand, d;
  int fails = 0, n_compared = 0, cycles = 0, lat;

  idm_core_model core (.clk(clk), .req_ready(req_ready), .resp_valid(resp_valid),
    .resp_data(resp_data), .req_valid(req_valid), .req(req));
  idm_data_space #(.RAM_DEPTH(256)) dut (.clk(clk), .rst_b(rst_b), .req_valid(req_valid),
    .req(req), .req_ready(req_ready), .resp_valid(resp_valid), .resp_data(resp_data),
    .stack_pointer(stack_pointer), .data_pointer_low(data_pointer_low),
    .data_pointer_high(data_pointer_high), .program_status_word(program_status_word),
    .accumulator(accumulator), .multiply_operand(multiply_operand));

  // ******************************************************************
  // Clock, timeout and closing report
  // ******************************************************************
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // Whole run needs under two hundred cycles; a hang is cut well above that
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      fails++;
      test_done();
    end
  end
  task automatic test_done();
    $display("comparisons %0d, mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // ******************************************************************
  // Scenarios
  // ******************************************************************
  task automatic go(idm_kind_type k, logic w, logic [7:0] a, logic [7:0] v);
    core.access(k, w, a, v, 0, d, lat);
  endtask

  task automatic reset_values();
    `CHK(stack_pointer, IDM_STACK_RESET)
    `CHK({data_pointer_low, data_pointer_high, program_status_word}, 24'h000000)
    `CHK({accumulator, multiply_operand}, 16'h0000)
    go(IDM_DIRECT, 1'b0, IDM_STACK_ADDR, 8'h00);
    `CHK(d, 8'h07)
  endtask

  // Same register number in every bank must land in a different byte
  task automatic bank_select();
    for (int b = 0; b < 4; b++) begin
      go(IDM_DIRECT, 1'b1, IDM_STATUS_ADDR, 8'(b << 3));
      go(IDM_REGISTER, 1'b1, 8'h07, 8'(8'ha0 + b));
      go(IDM_REGISTER, 1'b1, 8'h00, 8'(8'h30 + b));
      go(IDM_INDIRECT, 1'b1, 8'h00, 8'(8'hc0 + b));
      `CHK(lat, 2)
    end
    for (int b = 0; b < 4; b++) begin
      go(IDM_DIRECT, 1'b0, 8'(8 * b + 7), 8'h00);
      `CHK(d, 8'(8'ha0 + b))
      go(IDM_DIRECT, 1'b0, 8'(8'h30 + b), 8'h00);
      `CHK(d, 8'(8'hc0 + b))
    end
    `CHK(lat, 2)
    go(IDM_REGISTER, 1'b1, 8'h01, IDM_ACCUM_ADDR);
    go(IDM_INDIRECT, 1'b1, 8'h01, 8'h5a);
    go(IDM_INDIRECT, 1'b0, 8'h01, 8'h00);
    `CHK(d, 8'h5a)
    `CHK(lat, 3)
    go(IDM_DIRECT, 1'b0, IDM_ACCUM_ADDR, 8'h00);
    `CHK(d, 8'h00)
  endtask

  task automatic bit_area();
    go(IDM_DIRECT, 1'b1, 8'h22, 8'h00);
    go(IDM_BIT, 1'b1, 8'h13, 8'h01);
    go(IDM_DIRECT, 1'b0, 8'h22, 8'h00);
    `CHK(d, 8'h08)
    go(IDM_BIT, 1'b0, 8'h13, 8'h00);
    `CHK(d, 8'h01)
    go(IDM_BIT, 1'b0, 8'h12, 8'h00);
    `CHK(d, 8'h00)
    go(IDM_DIRECT, 1'b1, 8'h2f, 8'h80);
    go(IDM_BIT, 1'b0, 8'h7f, 8'h00);
    `CHK(d, 8'h01)
    go(IDM_DIRECT, 1'b1, 8'h20, 8'hfe);
    go(IDM_BIT, 1'b0, 8'h00, 8'h00);
    `CHK(d, 8'h00)
  endtask

  task automatic core_regs();
    go(IDM_BIT, 1'b1, 8'he3, 8'h01);
    `CHK(accumulator, 8'h08)
    go(IDM_BIT, 1'b1, 8'hf1, 8'h01);
    `CHK(multiply_operand, 8'h02)
    go(IDM_BIT, 1'b0, 8'he3, 8'h00);
    `CHK(d, 8'h01)
    `CHK(lat, 1)
    // Clearing the low select bit moves from bank three to bank two
    go(IDM_BIT, 1'b1, 8'hd3, 8'h00);
    go(IDM_REGISTER, 1'b0, 8'h00, 8'h00);
    `CHK(d, 8'h32)
    // Only occupied core register addresses are ever touched
    go(IDM_DIRECT, 1'b1, IDM_DATA_PTR_LO_ADDR, 8'h34);
    go(IDM_DIRECT, 1'b1, IDM_DATA_PTR_HI_ADDR, 8'h12);
    `CHK({data_pointer_high, data_pointer_low}, 16'h1234)
  endtask

  task automatic stack_ops();
    go(IDM_DIRECT, 1'b1, IDM_STATUS_ADDR, 8'h00);
    core.access(IDM_PUSH, 1'b0, 8'h00, 8'h11, 3, d, lat);
    `CHK(lat, 1)
    `CHK(stack_pointer, 8'h08)
    go(IDM_DIRECT, 1'b0, 8'h08, 8'h00);
    `CHK(d, 8'h11)
    go(IDM_DIRECT, 1'b1, IDM_STACK_ADDR, 8'hfe);
    go(IDM_PUSH, 1'b0, 8'h00, 8'h66);
    go(IDM_PUSH, 1'b0, 8'h00, 8'h77);
    `CHK(stack_pointer, 8'h00)
    go(IDM_REGISTER, 1'b0, 8'h00, 8'h00);
    `CHK(d, 8'h77)
    go(IDM_REGISTER, 1'b1, 8'h01, 8'hff);
    go(IDM_INDIRECT, 1'b0, 8'h01, 8'h00);
    `CHK(d, 8'h66)
    rst_b <= 1'b0;
    @(posedge clk);
    `CHK(stack_pointer, IDM_STACK_RESET)
    rst_b <= 1'b1;
    @(posedge clk);
    // First push after a mid-run reset lands at bank one register zero
    go(IDM_PUSH, 1'b1, 8'h00, 8'h5c);
    `CHK(stack_pointer, 8'h08)
    go(IDM_DIRECT, 1'b0, 8'h08, 8'h00);
    `CHK(d, 8'h5c)
  endtask

  // Main sequence
  initial begin
    rst_b = 1'b0;
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    reset_values();
    bank_select();
    bit_area();
    core_regs();
    stack_ops();
    test_done();
  end
endmodule
